//--- verilog/wdt_pkg.sv
package wdt_pkg;
    // Clock rates; the oscillator tick is derived from the system clock
    localparam int unsigned CLK_KHZ   = 100000;
    localparam int unsigned OSC_KHZ   = 32;
    localparam int unsigned OSC_DIV   = CLK_KHZ / OSC_KHZ;

    // Register byte offsets on the bus
    localparam logic [23:0] RESET_CTRL_OFF = 24'h000000;
    localparam logic [23:0] EVENT_OFF      = 24'h000004;
    localparam logic [23:0] MASK_OFF       = 24'h000008;
    localparam logic [23:0] COUNT_OFF      = 24'h00000C;
    localparam logic [23:0] CONFIG_OFF     = 24'h0057A0;

    // Reset control register bit positions
    localparam int unsigned RC_IDLE  = 2;
    localparam int unsigned RC_SLEEP = 3;
    localparam int unsigned RC_TOUT  = 4;
    localparam int unsigned RC_SWEN  = 5;

    // Configuration word layout
    localparam int unsigned CFG_W       = 24;
    localparam int unsigned CFG_POST    = 0;
    localparam int unsigned CFG_PRE     = 4;
    localparam int unsigned CFG_EN      = 5;
    localparam int unsigned CFG_WINDOW_DISABLE  = 7;
    localparam int unsigned CFG_WIN     = 8;
    localparam logic [1:0]  EN_ALWAYS   = 2'h3;
    localparam logic [1:0]  EN_SOFT     = 2'h2;

    // Prescaler terminal counts: 5-bit and 7-bit
    localparam logic [6:0]  PRE_TOP32   = 7'h1F;
    localparam logic [6:0]  PRE_TOP128  = 7'h7F;

    // Event bits
    localparam int unsigned EV_W       = 3;
    localparam int unsigned EV_TIMEOUT = 0;
    localparam int unsigned EV_EARLY   = 1;
    localparam int unsigned EV_WAKE    = 2;

    typedef enum logic [2:0] {
        ST_RUN   = 3'h1,
        ST_SLEEP = 3'h2,
        ST_IDLE  = 3'h4
    } pwr_state_t;
endpackage : wdt_pkg

//--- verilog/scaler_if.sv
`timescale 1ns/10ps
interface scaler_if;
    logic        clr;
    logic        tick;
    logic        pre_sel;
    logic [3:0]  post_sel;
    logic [1:0]  win_sel;
    logic        timeout;
    logic        in_window;
    logic [14:0] post_cnt;

    modport ctrl (output clr, tick, pre_sel, post_sel, win_sel,
                  input  timeout, in_window, post_cnt);
    modport core (input  clr, tick, pre_sel, post_sel, win_sel,
                  output timeout, in_window, post_cnt);
endinterface : scaler_if

//--- verilog/low_power_rc_osc_tick_div.sv
`timescale 1ns/10ps
module osc_tick_div #(
    parameter int unsigned DIV = wdt_pkg::OSC_DIV
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic run_i,
    input  wire logic clr_i,
    output logic      tick_o
);
    logic [11:0] cnt_ff;

    // Stopped oscillator holds phase at zero, so a fresh start is exact
    always_ff @(posedge clk_i) begin
        if (rst_i || !run_i || clr_i) begin
            cnt_ff <= 12'h000;
            tick_o <= 1'b0;
        end else if (cnt_ff == 12'(DIV - 1)) begin
            cnt_ff <= 12'h000;
            tick_o <= 1'b1;
        end else begin
            cnt_ff <= cnt_ff + 12'h001;
            tick_o <= 1'b0;
        end
    end
endmodule : osc_tick_div

//--- verilog/wdt_scaler.sv
`timescale 1ns/10ps
module wdt_scaler (
    input  wire logic clk_i,
    input  wire logic rst_i,
    scaler_if.core    sc
);
    logic [6:0]  pre_ff;
    logic [14:0] post_ff;
    logic        tout_ff;
    logic [6:0]  pre_top;
    logic [14:0] post_top;
    logic [25:0] prog8;
    logic [25:0] open_at;
    logic [2:0]  eighths;

    assign pre_top  = sc.pre_sel ? wdt_pkg::PRE_TOP128 : wdt_pkg::PRE_TOP32;
    assign post_top = 15'((16'h0001 << sc.post_sel) - 16'h0001);

    // Prescaler then postscaler; timeout on the last prescaler wrap
    always_ff @(posedge clk_i) begin
        if (rst_i || sc.clr) begin
            pre_ff  <= 7'h00;
            post_ff <= 15'h0000;
            tout_ff <= 1'b0;
        end else begin
            tout_ff <= 1'b0;
            if (sc.tick) begin
                if (pre_ff == pre_top) begin
                    pre_ff <= 7'h00;
                    if (post_ff == post_top) begin
                        post_ff <= 15'h0000;
                        tout_ff <= 1'b1;
                    end else begin
                        post_ff <= post_ff + 15'h0001;
                    end
                end else begin
                    pre_ff <= pre_ff + 7'h01;
                end
            end
        end
    end

    // Window opens when elapsed/period reaches eighths/8
    always_comb begin
        case (sc.win_sel)
            2'h3:    eighths = 3'h6;
            2'h2:    eighths = 3'h5;
            2'h1:    eighths = 3'h4;
            default: eighths = 3'h2;
        endcase
        if (sc.pre_sel) begin
            prog8   = {1'b0, post_ff, pre_ff, 3'h0};
            open_at = 26'({post_top + 16'h0001, 7'h00}) * 26'(eighths);
        end else begin
            prog8   = {3'h0, post_ff, pre_ff[4:0], 3'h0};
            open_at = 26'({post_top + 16'h0001, 5'h00}) * 26'(eighths);
        end
    end

    assign sc.in_window = (prog8 >= open_at);
    assign sc.timeout   = tout_ff;
    assign sc.post_cnt  = post_ff;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    pre_wrap_a: assert property (!sc.clr && sc.tick && pre_ff == pre_top
        |=> pre_ff == 7'h00) else $error("prescaler did not wrap");
    post_end_a: assert property (!sc.clr && sc.tick && pre_ff == pre_top
        && post_ff == post_top |=> tout_ff && post_ff == 15'h0000)
        else $error("postscaler end gave no timeout");
endmodule : wdt_scaler

//--- verilog/windowed_watchdog_timer.sv
// Functional notes
// - Counter runs on the low-power oscillator; enabling watchdog enables it.
// - Oscillator taken as nominal 32 kHz for all timeout periods.
// - Prescaler divides by 32 (5-bit) or 128 (7-bit) per select bit.
// - Postscaler adds sixteen ratios from 1:1 to 1:32768.
// - Postscale ratio comes from configuration bits 3 to 0.
// - Device reset or finished clock switch clears all counts.
// - Entering and leaving sleep or idle each clear the counts.
// - Clear instruction in normal execution clears all counts.
// - Watchdog runs in sleep and idle; timeout there wakes the core.
// - Enable field 11 keeps the watchdog always on.
// - Enable field 10 runs it only while software enable bit is set.
// - Software enable bit is cleared by every device reset.
// - Timeout sets a sticky flag that only software or power-on reset can clear.
// - Window disable bit zero makes clears obey the window size field.
`timescale 1ns/10ps
module windowed_watchdog_timer #(
    parameter int unsigned OSC_DIV = wdt_pkg::OSC_DIV
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        por_i,
    input  wire logic [23:0] config_word_i,
    input  wire logic        power_save_instr_i,
    input  wire logic        sleep_mode_i,
    input  wire logic        clear_watchdog_instr_i,
    input  wire logic        clk_switch_done_i,
    input  wire logic        wake_event_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [23:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    output logic             osc_en_o,
    output logic             wdt_reset_o,
    output logic             wake_o,
    output logic             irq_o
);
    scaler_if sc ();

    logic [23:0]         cfg_ff;
    wdt_pkg::pwr_state_t pwr_ff;
    logic                swen_ff;
    logic                tout_flag_ff;
    logic                sleep_bit_ff;
    logic                idle_bit_ff;
    logic [2:0]          ev_ff;
    logic [2:0]          mask_ff;
    logic [2:0]          nxt_ev;
    logic                run;
    logic                enter_ps;
    logic                leave_ps;
    logic                clr_cmd;
    logic                early_clr;
    logic                tick_w;
    logic                bus_req;
    logic                wr_lo;
    logic [1:0]          en_mode;

    // Write strobe for one register; all fields sit in byte lane 0
    function automatic logic wr_hit(input logic        wr,
                                    input logic [23:0] adr,
                                    input logic [23:0] off);
        wr_hit = wr && (adr == off);
    endfunction : wr_hit

    // Configuration is latched during reset and frozen afterwards
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_ff <= config_word_i;
        end
    end

    assign en_mode = cfg_ff[wdt_pkg::CFG_EN +: 2];

    // Enable decode: fixed on, or software controlled
    assign run = (en_mode == wdt_pkg::EN_ALWAYS)
        || (en_mode == wdt_pkg::EN_SOFT && swen_ff);

    // Oscillator follows the enable so it burns power only when needed
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            osc_en_o <= 1'b0;
        end else begin
            osc_en_o <= run;
        end
    end

    // 32 kHz tick as an enable pulse from the system clock
    osc_tick_div #(
        .DIV(OSC_DIV)
    ) u_div (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .run_i (run),
        .clr_i (clr_cmd),
        .tick_o(tick_w)
    );

    assign enter_ps  = (pwr_ff == wdt_pkg::ST_RUN) && power_save_instr_i;
    assign leave_ps  = (pwr_ff != wdt_pkg::ST_RUN)
        && (wake_event_i || (run && sc.timeout));
    assign early_clr = (pwr_ff == wdt_pkg::ST_RUN) && clear_watchdog_instr_i
        && run && !cfg_ff[wdt_pkg::CFG_WINDOW_DISABLE] && !sc.in_window;

    // Any of these restarts the whole count chain
    assign clr_cmd = clk_switch_done_i
        || enter_ps || leave_ps
        || ((pwr_ff == wdt_pkg::ST_RUN) && clear_watchdog_instr_i)
        || !run;

    assign sc.clr      = clr_cmd;
    assign sc.tick     = tick_w;
    assign sc.pre_sel  = cfg_ff[wdt_pkg::CFG_PRE];
    assign sc.post_sel = cfg_ff[wdt_pkg::CFG_POST +: 4];
    assign sc.win_sel  = cfg_ff[wdt_pkg::CFG_WIN +: 2];

    wdt_scaler u_scaler (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sc   (sc)
    );

    // Power state; the counter keeps running while asleep
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pwr_ff <= wdt_pkg::ST_RUN;
        end else begin
            case (pwr_ff)
                wdt_pkg::ST_RUN: begin
                    if (power_save_instr_i) begin
                        pwr_ff <= sleep_mode_i ? wdt_pkg::ST_SLEEP
                                               : wdt_pkg::ST_IDLE;
                    end
                end
                wdt_pkg::ST_SLEEP, wdt_pkg::ST_IDLE: begin
                    if (leave_ps) begin
                        pwr_ff <= wdt_pkg::ST_RUN;
                    end
                end
                default: pwr_ff <= wdt_pkg::ST_RUN;
            endcase
        end
    end

    // Reset request and wake pulses, one cycle each
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wdt_reset_o <= 1'b0;
            wake_o      <= 1'b0;
        end else begin
            wdt_reset_o <= (pwr_ff == wdt_pkg::ST_RUN && run && sc.timeout)
                || early_clr;
            wake_o      <= leave_ps && run && sc.timeout;
        end
    end

    // Bus handshake: ack one cycle after the request, dropped next cycle
    assign bus_req = wb_cyc_i && wb_stb_i;
    assign wr_lo   = bus_req && wb_we_i && wb_ack_o && wb_sel_i[0];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_req && !wb_ack_o;
        end
    end

    // Software enable dies with every device reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            swen_ff <= 1'b0;
        end else if (wr_hit(wr_lo, wb_adr_i, wdt_pkg::RESET_CTRL_OFF)) begin
            swen_ff <= wb_dat_i[wdt_pkg::RC_SWEN];
        end
    end

    // Status flags survive the watchdog's own reset; only power-on or a software write clears
    always_ff @(posedge clk_i) begin
        if (por_i) begin
            tout_flag_ff <= 1'b0;
            sleep_bit_ff <= 1'b0;
            idle_bit_ff  <= 1'b0;
        end else begin
            if (wr_hit(wr_lo, wb_adr_i, wdt_pkg::RESET_CTRL_OFF)) begin
                tout_flag_ff <= wb_dat_i[wdt_pkg::RC_TOUT];
                sleep_bit_ff <= wb_dat_i[wdt_pkg::RC_SLEEP];
                idle_bit_ff  <= wb_dat_i[wdt_pkg::RC_IDLE];
            end
            // Hardware sets win over a clearing write
            if (run && sc.timeout) begin
                tout_flag_ff <= 1'b1;
            end
            if (enter_ps && sleep_mode_i) begin
                sleep_bit_ff <= 1'b1;
            end
            if (enter_ps && !sleep_mode_i) begin
                idle_bit_ff <= 1'b1;
            end
        end
    end

    // Sticky events, write one to clear; a new event beats the clear
    always_comb begin
        nxt_ev = ev_ff;
        if (wr_hit(wr_lo, wb_adr_i, wdt_pkg::EVENT_OFF)) begin
            nxt_ev = ev_ff & ~wb_dat_i[2:0];
        end
        nxt_ev[wdt_pkg::EV_TIMEOUT] = nxt_ev[wdt_pkg::EV_TIMEOUT]
            || (run && sc.timeout);
        nxt_ev[wdt_pkg::EV_EARLY] = nxt_ev[wdt_pkg::EV_EARLY] || early_clr;
        nxt_ev[wdt_pkg::EV_WAKE] = nxt_ev[wdt_pkg::EV_WAKE] || leave_ps;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ev_ff   <= 3'h0;
            mask_ff <= 3'h0;
            irq_o   <= 1'b0;
        end else begin
            ev_ff <= nxt_ev;
            if (wr_hit(wr_lo, wb_adr_i, wdt_pkg::MASK_OFF)) begin
                mask_ff <= wb_dat_i[2:0];
            end
            irq_o <= |(nxt_ev & mask_ff);
        end
    end

    // Read data latched as ack rises; unmapped reads return zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h00000000;
        end else if (bus_req && !wb_ack_o) begin
            case (wb_adr_i)
                wdt_pkg::RESET_CTRL_OFF:
                    wb_dat_o <= {26'h0, swen_ff, tout_flag_ff,
                                 sleep_bit_ff, idle_bit_ff, 2'h0};
                wdt_pkg::EVENT_OFF: wb_dat_o <= {29'h0, ev_ff};
                wdt_pkg::MASK_OFF:  wb_dat_o <= {29'h0, mask_ff};
                wdt_pkg::COUNT_OFF: wb_dat_o <= {17'h0, sc.post_cnt};
                wdt_pkg::CONFIG_OFF: wb_dat_o <= {8'h00, cfg_ff};
                default: wb_dat_o <= 32'h00000000;
            endcase
        end
    end

    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    osc_follow_a: assert property (run |=> osc_en_o)
        else $error("oscillator not enabled with watchdog");
    always_on_a: assert property (en_mode == wdt_pkg::EN_ALWAYS |-> run)
        else $error("always-on mode not running");
    soft_mode_a: assert property (en_mode == wdt_pkg::EN_SOFT
        |-> run == swen_ff) else $error("soft enable not obeyed");
    cfg_fixed_a: assert property (##1 $stable(cfg_ff))
        else $error("configuration changed at run time");
    switch_clr_a: assert property (clk_switch_done_i
        |=> sc.post_cnt == 15'h0000 && !sc.timeout)
        else $error("clock switch did not clear counts");
    ps_clr_a: assert property (enter_ps || leave_ps
        |=> sc.post_cnt == 15'h0000) else $error("power save kept counts");
    instr_clr_a: assert property (pwr_ff == wdt_pkg::ST_RUN
        && clear_watchdog_instr_i |=> sc.post_cnt == 15'h0000 && !sc.timeout)
        else $error("clear instruction kept counts");
    sleep_wake_a: assert property (pwr_ff != wdt_pkg::ST_RUN && run
        && sc.timeout |=> wake_o && pwr_ff == wdt_pkg::ST_RUN && !wdt_reset_o)
        else $error("timeout in power save did not wake");
    swen_reset_a: assert property (disable iff (1'b0)
        rst_i |=> !swen_ff) else $error("soft enable survived reset");
    flag_sticky_a: assert property (disable iff (por_i) tout_flag_ff
        && !wr_hit(wr_lo, wb_adr_i, wdt_pkg::RESET_CTRL_OFF) |=> tout_flag_ff)
        else $error("timeout flag cleared by hardware");
    early_rst_a: assert property (early_clr |=> wdt_reset_o
        && ev_ff[wdt_pkg::EV_EARLY]) else $error("early clear not punished");
    run_rst_a: assert property (pwr_ff == wdt_pkg::ST_RUN && run
        && sc.timeout |=> wdt_reset_o ##1 !wdt_reset_o)
        else $error("timeout gave no single reset pulse");

    // A stopped watchdog stays silent; power-save steps leave a record
    cnt_hold_a: assert property (!run |=> sc.post_cnt == 15'h0000)
        else $error("disabled watchdog kept counting");
    tick_stop_a: assert property (!run |=> !tick_w)
        else $error("oscillator tick while disabled");
    ps_flag_a: assert property (enter_ps && sleep_mode_i
        |=> sleep_bit_ff) else $error("sleep entry not recorded");
    ev_wake_a: assert property (leave_ps
        |=> ev_ff[wdt_pkg::EV_WAKE]) else $error("wake event not recorded");

    tout_rst_c: cover property (run && sc.timeout
        && pwr_ff == wdt_pkg::ST_RUN);
    wake_c: cover property (enter_ps ##[1:1000] wake_o);
    early_c: cover property (early_clr);
    sleep_c: cover property (enter_ps && sleep_mode_i);
    swen_c: cover property (en_mode == wdt_pkg::EN_SOFT && $rose(swen_ff));
endmodule : windowed_watchdog_timer

//--- tb/windowed_watchdog_timer_tb.sv
`timescale 1ns/10ps
module windowed_watchdog_timer_tb;
    localparam int unsigned DIV = 4;
    logic        clk_i, rst_i, por_i, power_save_instr_i, sleep_mode_i;
    logic        clear_watchdog_instr_i, clk_switch_done_i, wake_event_i;
    logic        wb_cyc_i, wb_stb_i, wb_we_i;
    logic [23:0] config_word_i, wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, q;
    logic        wb_ack_o, osc_en_o, wdt_reset_o, wake_o, irq_o;
    int          err_count, num_checks, n, i, s, t;
    // Ordinary cases: config word beside the ticks it should time out after
    logic [23:0] row_cfg [5] = '{24'h0000E0, 24'h0000F0, 24'h0000E1,
                                 24'h0000E3, 24'h0000F2};
    int          row_t   [5] = '{32, 128, 64, 256, 512};
    int          fr      [4] = '{2, 4, 5, 6};

    windowed_watchdog_timer #(.OSC_DIV(DIV)) windowed_watchdog_timer_inst (
        .clk_i(clk_i), .rst_i(rst_i), .por_i(por_i),
        .config_word_i(config_word_i),
        .power_save_instr_i(power_save_instr_i), .sleep_mode_i(sleep_mode_i),
        .clear_watchdog_instr_i(clear_watchdog_instr_i),
        .clk_switch_done_i(clk_switch_done_i), .wake_event_i(wake_event_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .osc_en_o(osc_en_o),
        .wdt_reset_o(wdt_reset_o), .wake_o(wake_o), .irq_o(irq_o));

    // Free-running 100 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic finish_test;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                       input string nm);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    function automatic logic [23:0] mk(input logic [1:0] w, input logic wd,
                                       input logic [1:0] en);
        mk = {14'h0000, w, wd, en, 1'b0, 4'h0};
    endfunction : mk

    // Classic cycle: hold everything until ack is sampled, then release
    task automatic wb_xfer(input logic we, input logic [23:0] a,
                           input logic [31:0] d, output logic [31:0] r);
        int k;
        k = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hF;
        do begin
            @(posedge clk_i);
            k++;
            if (k > 20) begin
                err_count++;
                finish_test();
            end
        end while (wb_ack_o !== 1'b1);
        r = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : wb_xfer

    task automatic rd(input logic [23:0] a, input logic [31:0] e,
                      input string nm);
        logic [31:0] r;
        wb_xfer(1'b0, a, 32'h0, r);
        chk(r, e, nm);
    endtask : rd

    task automatic wr(input logic [23:0] a, input logic [31:0] d);
        logic [31:0] r;
        wb_xfer(1'b1, a, d, r);
    endtask : wr

    // Config is latched only while reset is high
    task automatic do_reset(input logic [23:0] cfg, input logic por);
        @(posedge clk_i);
        rst_i         <= 1'b1;
        por_i         <= por;
        config_word_i <= cfg;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        por_i <= 1'b0;
    endtask : do_reset

    task automatic pulse(input int which);
        @(posedge clk_i);
        case (which)
            0: clear_watchdog_instr_i <= 1'b1;
            1: clk_switch_done_i      <= 1'b1;
            2: power_save_instr_i     <= 1'b1;
            default: wake_event_i     <= 1'b1;
        endcase
        @(posedge clk_i);
        clear_watchdog_instr_i <= 1'b0;
        clk_switch_done_i      <= 1'b0;
        power_save_instr_i     <= 1'b0;
        wake_event_i           <= 1'b0;
    endtask : pulse

    // Counts edges until the chosen pulse is seen; a miss ends the run
    task automatic wait_out(input int sel, input int bound, output int cnt);
        cnt = 0;
        do begin
            @(posedge clk_i);
            cnt++;
            if (cnt > bound) begin
                err_count++;
                finish_test();
            end
        end while (((sel == 1) ? wake_o : wdt_reset_o) !== 1'b1);
    endtask : wait_out

    task automatic quiet(input int cyc, input string nm);
        logic seen;
        seen = 1'b0;
        repeat (cyc) begin
            @(posedge clk_i);
            if (wdt_reset_o === 1'b1 || wake_o === 1'b1) seen = 1'b1;
        end
        chk({31'h0, seen}, 32'h0, nm);
    endtask : quiet

    function automatic logic near(input int got, input int exp);
        near = (got >= exp - 2) && (got <= exp + 4);
    endfunction : near

    initial begin
        {rst_i, por_i, power_save_instr_i, sleep_mode_i} = 4'h8;
        {clear_watchdog_instr_i, clk_switch_done_i, wake_event_i} = 3'h0;
        {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
        config_word_i = 24'h0;
        wb_adr_i = 24'h0;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0;
        err_count = 0;
        num_checks = 0;
        // Period table: one reset per row, timed to the reset request
        for (i = 0; i < 5; i++) begin
            do_reset(row_cfg[i], 1'b1);
            wait_out(0, 5000, n);
            chk(near(n, row_t[i] * DIV), 1'b1,
                "period");
            chk(osc_en_o, 1'b1, "osc enable");
            rd(wb_pkg_cfg(), {8'h00, row_cfg[i]}, "config");
        end
        // Software enable mode, sticky flag, interrupt path
        do_reset(mk(2'h0, 1'b1, wdt_pkg::EN_SOFT), 1'b1);
        rd(wdt_pkg::RESET_CTRL_OFF, 32'h0, "reset ctrl");
        rd(wdt_pkg::MASK_OFF, 32'h0, "mask");
        rd(24'h000010, 32'h0, "unmapped");
        wr(wdt_pkg::CONFIG_OFF, 32'h0);
        rd(wdt_pkg::CONFIG_OFF, 32'h000000C0, "config ro");
        chk(osc_en_o, 1'b0, "osc off");
        quiet(300, "soft off");
        wr(wdt_pkg::RESET_CTRL_OFF, 32'h20);
        wait_out(0, 200, n);
        chk(near(n, 32 * DIV), 1'b1, "soft period");
        chk(osc_en_o, 1'b1, "osc on");
        rd(wdt_pkg::RESET_CTRL_OFF, 32'h30, "flag set");
        rd(wdt_pkg::EVENT_OFF, 32'h1, "event");
        chk(irq_o, 1'b0, "irq masked");
        wr(wdt_pkg::MASK_OFF, 32'h1);
        // The new mask reaches irq one edge after the write lands
        repeat (2) @(posedge clk_i);
        chk(irq_o, 1'b1, "irq");
        wr(wdt_pkg::EVENT_OFF, 32'h1);
        @(posedge clk_i);
        chk(irq_o, 1'b0, "irq cleared");
        do_reset(mk(2'h0, 1'b1, wdt_pkg::EN_SOFT), 1'b0);
        rd(wdt_pkg::RESET_CTRL_OFF, 32'h10, "after reset");
        wr(wdt_pkg::RESET_CTRL_OFF, 32'h0);
        rd(wdt_pkg::RESET_CTRL_OFF, 32'h0, "flag clear");
        // Disabled modes hold the counter and oscillator off
        for (s = 0; s < 2; s++) begin
            do_reset(mk(2'h0, 1'b1, s[1:0]), 1'b1);
            chk(osc_en_o, 1'b0, "osc disabled");
            quiet(300, "disabled");
        end
        // Clear instruction and clock switch restart the full period
        for (s = 0; s < 2; s++) begin
            do_reset(mk(2'h0, 1'b1, wdt_pkg::EN_ALWAYS), 1'b1);
            repeat (100) @(posedge clk_i);
            pulse(s);
            wait_out(0, 400, n);
            chk(near(n, 32 * DIV), 1'b1, "restart");
        end
        // Idle entry, then a wake source: exit restarts the count
        sleep_mode_i <= 1'b0;
        pulse(2);
        // Timeout flag from the last restart check is still standing
        rd(wdt_pkg::RESET_CTRL_OFF, 32'h14, "idle bit");
        repeat (50) @(posedge clk_i);
        pulse(3);
        wait_out(0, 400, n);
        chk(near(n, 32 * DIV), 1'b1, "exit restart");
        rd(wdt_pkg::EVENT_OFF, 32'h5, "wake event");
        // Sleep: clear is ignored and the timeout wakes the core
        do_reset(mk(2'h0, 1'b1, wdt_pkg::EN_ALWAYS), 1'b1);
        sleep_mode_i <= 1'b1;
        pulse(2);
        repeat (60) @(posedge clk_i);
        pulse(0);
        wait_out(1, 400, n);
        chk(near(n, 32 * DIV - 63), 1'b1, "sleep wake");
        rd(wdt_pkg::RESET_CTRL_OFF, 32'h18, "sleep flags");
        wr(wdt_pkg::RESET_CTRL_OFF, 32'h0);
        rd(wdt_pkg::RESET_CTRL_OFF, 32'h0, "sleep cleared");
        // Postscaler count is visible between its first and second step
        do_reset(24'h0000E3, 1'b1);
        repeat (200) @(posedge clk_i);
        rd(wdt_pkg::COUNT_OFF, 32'h1, "post count");
        // Window: a clear just before opening resets, just after does not
        for (s = 0; s < 4; s++) begin
            do_reset(mk(s[1:0], 1'b0, wdt_pkg::EN_ALWAYS), 1'b1);
            t = 32 * DIV * fr[s] / 8;
            repeat (t - 10) @(posedge clk_i);
            pulse(0);
            wait_out(0, 4, n);
            chk(n, 1, "early clear");
            repeat (t + 8) @(posedge clk_i);
            pulse(0);
            quiet(20, "in window");
        end
        rd(wdt_pkg::EVENT_OFF, 32'h2, "early event");
        finish_test();
    end

    function automatic logic [23:0] wb_pkg_cfg();
        wb_pkg_cfg = wdt_pkg::CONFIG_OFF;
    endfunction : wb_pkg_cfg
endmodule : windowed_watchdog_timer_tb
